//--- pkg/phc_defines.vh
`ifndef PHC_DEFINES_VH
`define PHC_DEFINES_VH

// Register offsets
`define PHC_OFF_FIFO_LEVEL_SELECT    6'h03
`define PHC_OFF_SYNC_HI     6'h04
`define PHC_OFF_SYNC_LO     6'h05
`define PHC_OFF_FRAME_LIM   6'h06
`define PHC_OFF_AUTO_A      6'h07
`define PHC_OFF_AUTO_B      6'h08
`define PHC_OFF_NODE_ADDR   6'h09

// Reset values
`define PHC_RST_FIFO_LEVEL_SELECT    8'h07
`define PHC_RST_SYNC_HI     8'hD3
`define PHC_RST_SYNC_LO     8'h91
`define PHC_RST_FRAME_LIM   8'hFF
`define PHC_RST_AUTO_A      8'h04
`define PHC_RST_AUTO_B      8'h45
`define PHC_RST_NODE_ADDR   8'h00

// Field positions
`define PHC_THR_MSB         3
`define PHC_THR_LSB         0
`define PHC_FLUSH_BIT       3
`define PHC_TRAILER_BIT     2
`define PHC_ADDR_MODE_MSB   1
`define PHC_ADDR_MODE_LSB   0
`define PHC_LEN_MODE_MSB    1
`define PHC_LEN_MODE_LSB    0
`define PHC_AUTO_A_RO_MASK  8'hEF
`define PHC_AUTO_B_RO_MASK  8'h77

// Modes
`define PHC_LEN_FIXED       2'b00
`define PHC_LEN_VAR         2'b01
`define PHC_ADDR_NONE       2'b00
`define PHC_ADDR_OWN        2'b01
`define PHC_ADDR_BC0        2'b10
`define PHC_ADDR_BC0_FF     2'b11
`define PHC_BCAST_ZERO      8'h00
`define PHC_BCAST_ONES      8'hFF

// FIFO sizing and threshold arithmetic
`define PHC_FIFO_DEPTH      64
`define PHC_THR_STEP        7'h04
`define PHC_TX_THR_BASE     7'h3D

`endif

//--- core/phc_pair_buf.v
`timescale 1ns/1ps
// Two-entry buffer; a stall at the output never loses a byte
module phc_pair_buf #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  input  wire             flush,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0]       fill;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (fill != 2'd2);
  assign out_valid = (fill != 2'd0);
  assign out_data  = slot0;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
      fill  <= 2'd0;
    end else if (flush) begin
      fill <= 2'd0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (fill == 2'd0) slot0 <= in_data;
          else slot1 <= in_data;
          fill <= fill + 2'd1;
        end
        2'b01: begin
          slot0 <= slot1;
          fill  <= fill - 2'd1;
        end
        2'b11: begin
          if (fill == 2'd1) slot0 <= in_data;
          else begin
            slot0 <= slot1;
            slot1 <= in_data;
          end
        end
        default: fill <= fill;
      endcase
    end
  end
endmodule // phc_pair_buf

//--- core/phc_packet_handler.v
// Operation
// R1: Threshold select n gives an RX FIFO level of 4*(n+1) bytes and a TX level of 61-4n, reset 7.
// R2: A FIFO threshold counts as reached when its byte count is at least the level.
// R3: The sync word high byte is a read/write register resetting to 0xD3.
// R4: The sync word low byte is a read/write register resetting to 0x91.
// R5: In fixed length mode the length register, reset 0xFF, is the exact payload size.
// R6: In variable length mode the length register is the largest accepted packet length.
// R7: The host never writes zero into the length register.
// R8: In variable length mode the packet length is the first byte after the sync word.
// R9: With flush-on-bad-check set (reset 0) a packet failing its CRC empties the RX FIFO.
// R10: With flush-on-bad-check the host keeps one packet in the RX FIFO, no longer than it.
// R11: With trailer info set (reset 1) two status bytes follow each received payload.
// R12: The status bytes carry signal strength and a CRC passed flag.
// R13: Address filter mode 00 none, 01 own, 10 own or 0x00, 11 own or 0x00 or 0xFF.
// R14: In mode 01 only packets addressed to the own address are accepted.
// R15: The compared address is the own-node address register; 0x00 and 0xFF are broadcasts.
// R16: A packet failing the enabled address check is discarded and never reaches the RX FIFO.
`timescale 1ns/1ps
`include "phc_defines.vh"
module phc_packet_handler #(
  parameter DEPTH = `PHC_FIFO_DEPTH,
  parameter CW    = 7
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // Register port
  input  wire [5:0]   reg_addr,
  input  wire         reg_wr,
  input  wire         reg_rd,
  input  wire [7:0]   reg_wdata,
  output reg  [7:0]   reg_rdata,
  // Demodulator byte stream
  input  wire         rx_sync_found,
  input  wire         rx_byte_valid,
  output wire         rx_byte_ready,
  input  wire [7:0]   rx_byte,
  input  wire         rx_pkt_end,
  input  wire         rx_crc_ok,
  input  wire [7:0]   rx_rssi,
  // Sync word to the correlator
  output wire [15:0]  sync_word,
  // RX FIFO host side
  input  wire         rx_fifo_rd,
  output reg  [7:0]   rx_fifo_data,
  output wire [CW-1:0] rx_fifo_count,
  output wire         rx_thr_hit,
  // TX FIFO level from the transmit path
  input  wire [CW-1:0] tx_fifo_count,
  output wire         tx_thr_hit,
  // Packet events
  output reg          pkt_drop,
  output reg          pkt_flushed
);
  localparam S_IDLE  = 4'd0;
  localparam S_LEN   = 4'd1;
  localparam S_ADDR  = 4'd2;
  localparam S_PLEN  = 4'd3;
  localparam S_PADR  = 4'd4;
  localparam S_DATA  = 4'd5;
  localparam S_END   = 4'd6;
  localparam S_ST1   = 4'd7;
  localparam S_ST2   = 4'd8;
  localparam S_DROP  = 4'd9;

  reg [7:0] fifo_level_select_reg;
  reg [7:0] sync_hi;
  reg [7:0] sync_lo;
  reg [7:0] frame_lim;
  reg [7:0] auto_a;
  reg [7:0] auto_b;
  reg [7:0] node_addr;

  wire [3:0] fifo_level_select = fifo_level_select_reg[`PHC_THR_MSB:`PHC_THR_LSB];
  wire       bad_check_flush_en = auto_a[`PHC_FLUSH_BIT];
  wire       trailer_info_en = auto_a[`PHC_TRAILER_BIT];
  wire [1:0] addr_filter_mode = auto_a[`PHC_ADDR_MODE_MSB:`PHC_ADDR_MODE_LSB];
  wire [1:0] len_mode = auto_b[`PHC_LEN_MODE_MSB:`PHC_LEN_MODE_LSB];

  function [CW-1:0] rx_level;
    input [3:0] n;
    rx_level = `PHC_THR_STEP * ({3'b000, n} + 7'd1);
  endfunction

  function [CW-1:0] tx_level;
    input [3:0] n;
    tx_level = `PHC_TX_THR_BASE - `PHC_THR_STEP * {3'b000, n};
  endfunction

  function addr_pass;
    input [1:0] mode;
    input [7:0] a;
    input [7:0] own;
    case (mode)
      `PHC_ADDR_NONE: addr_pass = 1'b1;
      `PHC_ADDR_OWN:  addr_pass = (a == own);
      `PHC_ADDR_BC0:  addr_pass = (a == own) || (a == `PHC_BCAST_ZERO);
      default:        addr_pass = (a == own) || (a == `PHC_BCAST_ZERO) ||
                                  (a == `PHC_BCAST_ONES);
    endcase
  endfunction

  // Register writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_level_select_reg <= `PHC_RST_FIFO_LEVEL_SELECT; // R1
      sync_hi      <= `PHC_RST_SYNC_HI; // R3
      sync_lo      <= `PHC_RST_SYNC_LO; // R4
      frame_lim    <= `PHC_RST_FRAME_LIM; // R5
      auto_a       <= `PHC_RST_AUTO_A; // R9 R11 R13
      auto_b       <= `PHC_RST_AUTO_B;
      node_addr    <= `PHC_RST_NODE_ADDR;
    end else if (reg_wr) begin
      case (reg_addr)
        `PHC_OFF_FIFO_LEVEL_SELECT:  fifo_level_select_reg <= reg_wdata; // R1
        `PHC_OFF_SYNC_HI:   sync_hi <= reg_wdata; // R3
        `PHC_OFF_SYNC_LO:   sync_lo <= reg_wdata; // R4
        `PHC_OFF_FRAME_LIM: frame_lim <= reg_wdata; // R7
        `PHC_OFF_AUTO_A:    auto_a <= reg_wdata & `PHC_AUTO_A_RO_MASK;
        `PHC_OFF_AUTO_B:    auto_b <= reg_wdata & `PHC_AUTO_B_RO_MASK;
        `PHC_OFF_NODE_ADDR: node_addr <= reg_wdata; // R15
        default:            node_addr <= node_addr;
      endcase
    end
  end

  // Register reads, captured on the read strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PHC_OFF_FIFO_LEVEL_SELECT:  reg_rdata <= fifo_level_select_reg;
        `PHC_OFF_SYNC_HI:   reg_rdata <= sync_hi;
        `PHC_OFF_SYNC_LO:   reg_rdata <= sync_lo;
        `PHC_OFF_FRAME_LIM: reg_rdata <= frame_lim;
        `PHC_OFF_AUTO_A:    reg_rdata <= auto_a;
        `PHC_OFF_AUTO_B:    reg_rdata <= auto_b;
        `PHC_OFF_NODE_ADDR: reg_rdata <= node_addr;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  assign sync_word = {sync_hi, sync_lo}; // R3 R4

  // Packet sequencer
  reg [3:0] state;
  reg [7:0] held_len;
  reg [7:0] held_addr;
  reg [7:0] remain;
  reg [7:0] st_rssi;
  reg       st_crc;
  reg       flush_req;
  reg       push_valid;
  reg [7:0] push_data;
  wire      push_ready;
  wire      take = rx_byte_valid & rx_byte_ready;

  // Bytes are only taken when the buffer can take one, so the source stalls
  assign rx_byte_ready = push_ready &&
                         ((state == S_LEN) || (state == S_ADDR) ||
                          (state == S_DATA) || (state == S_DROP));

  always @* begin
    push_valid = 1'b0;
    push_data  = rx_byte;
    case (state)
      S_PLEN: begin
        push_valid = 1'b1;
        push_data  = held_len;
      end
      S_PADR: begin
        push_valid = 1'b1;
        push_data  = held_addr;
      end
      S_DATA: push_valid = rx_byte_valid;
      S_ST1: begin
        push_valid = 1'b1;
        push_data  = st_rssi; // R12
      end
      S_ST2: begin
        push_valid = 1'b1;
        push_data  = {st_crc, 7'h00}; // R12
      end
      default: push_valid = 1'b0;
    endcase
  end

  wire pushed = push_valid & push_ready;
  wire filt_on = (addr_filter_mode != `PHC_ADDR_NONE);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= S_IDLE;
      held_len    <= 8'h00;
      held_addr   <= 8'h00;
      remain      <= 8'h00;
      st_rssi     <= 8'h00;
      st_crc      <= 1'b0;
      flush_req   <= 1'b0;
      pkt_drop    <= 1'b0;
      pkt_flushed <= 1'b0;
    end else begin
      flush_req   <= 1'b0;
      pkt_drop    <= 1'b0;
      pkt_flushed <= 1'b0;
      if (rx_sync_found) begin
        // A fresh sync word restarts framing
        held_len <= 8'h00;
        remain   <= frame_lim; // R5
        if (len_mode == `PHC_LEN_VAR) state <= S_LEN; // R8
        else if (filt_on) state <= S_ADDR;
        else state <= S_DATA;
      end else begin
        case (state)
          S_LEN: if (take) begin
            held_len <= rx_byte; // R8
            remain   <= rx_byte;
            if (rx_byte > frame_lim || rx_byte == 8'h00) begin
              state    <= S_DROP; // R6
              pkt_drop <= 1'b1;
            end else if (filt_on) state <= S_ADDR;
            else state <= S_PLEN;
          end
          S_ADDR: if (take) begin
            held_addr <= rx_byte;
            remain    <= remain - 8'd1;
            if (addr_pass(addr_filter_mode, rx_byte, node_addr)) begin // R13 R14 R15
              state <= (len_mode == `PHC_LEN_VAR) ? S_PLEN : S_PADR;
            end else begin
              state    <= S_DROP; // R16
              pkt_drop <= 1'b1;
            end
          end
          S_PLEN: if (pushed) state <= filt_on ? S_PADR : S_DATA;
          S_PADR: if (pushed) state <= (remain == 8'h00) ? S_END : S_DATA;
          S_DATA: if (pushed) begin
            remain <= remain - 8'd1;
            if (remain == 8'd1) state <= S_END; // R5 R6
          end
          S_END: if (rx_pkt_end) begin
            st_rssi <= rx_rssi;
            st_crc  <= rx_crc_ok;
            if (!rx_crc_ok && bad_check_flush_en) begin
              flush_req   <= 1'b1; // R9
              pkt_flushed <= 1'b1;
              state       <= S_IDLE;
            end else if (trailer_info_en) state <= S_ST1; // R11
            else state <= S_IDLE;
          end
          S_ST1: if (pushed) state <= S_ST2; // R11
          S_ST2: if (pushed) state <= S_IDLE;
          S_DROP: if (rx_pkt_end) state <= S_IDLE;
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Buffer between sequencer and FIFO store
  wire       buf_valid;
  wire [7:0] buf_data;
  reg  [CW-1:0] count;
  wire       store_ready = (count < DEPTH);

  phc_pair_buf #(
    .WIDTH (8)
  ) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (flush_req),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (buf_valid),
    .out_ready (store_ready),
    .out_data  (buf_data)
  );

  // RX FIFO store in flip-flops
  reg [7:0]    mem [0:DEPTH-1];
  reg [CW-2:0] wr_ptr;
  reg [CW-2:0] rd_ptr;
  wire wr_en = buf_valid & store_ready;
  wire rd_en = rx_fifo_rd & (count != {CW{1'b0}});
  integer i;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < DEPTH; i = i + 1) mem[i] <= 8'h00;
      wr_ptr       <= {(CW-1){1'b0}};
      rd_ptr       <= {(CW-1){1'b0}};
      count        <= {CW{1'b0}};
      rx_fifo_data <= 8'h00;
    end else if (flush_req) begin
      // Flush wins over any write or read in the same cycle
      wr_ptr <= {(CW-1){1'b0}}; // R9
      rd_ptr <= {(CW-1){1'b0}};
      count  <= {CW{1'b0}};
    end else begin
      if (wr_en) begin
        mem[wr_ptr] <= buf_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (rd_en) begin
        rx_fifo_data <= mem[rd_ptr];
        rd_ptr       <= rd_ptr + 1'b1;
      end
      count <= count + {{(CW-1){1'b0}}, wr_en} - {{(CW-1){1'b0}}, rd_en};
    end
  end

  assign rx_fifo_count = count;
  assign rx_thr_hit = (count >= rx_level(fifo_level_select)); // R1 R2
  assign tx_thr_hit = (tx_fifo_count >= tx_level(fifo_level_select)); // R1 R2
endmodule // phc_packet_handler

//--- tb/phc_asserts.sv
`timescale 1ns/1ps
module phc_asserts #(parameter CW = 7) (
  // Clock and reset
  input wire          clk,
  input wire          rst_b,
  // Register port
  input wire [5:0]    reg_addr,
  input wire          reg_wr,
  input wire          reg_rd,
  input wire [7:0]    reg_wdata,
  input wire [7:0]    reg_rdata,
  // Stream and levels
  input wire          rx_sync_found,
  input wire          rx_byte_ready,
  input wire [15:0]   sync_word,
  input wire [CW-1:0] rx_fifo_count,
  input wire          rx_thr_hit,
  input wire [CW-1:0] tx_fifo_count,
  input wire          tx_thr_hit,
  input wire          pkt_drop,
  input wire          pkt_flushed
);
  reg [3:0] thr;
  reg       synced;
  // Shadow of the level select, since the checker only sees ports
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thr <= 4'h7;
      synced <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 6'h03) thr <= reg_wdata[3:0];
      if (rx_sync_found) synced <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence rd_hi_s; reg_rd && reg_addr == 6'h04; endsequence
  sequence wr_lo_s; reg_wr && reg_addr == 6'h05; endsequence
  rx_level_a: assert property (
    rx_thr_hit == (rx_fifo_count >= 4 * (thr + 1))) else $error("rx level flag wrong");
  tx_level_a: assert property (
    tx_thr_hit == (tx_fifo_count >= 61 - 4 * thr)) else $error("tx level flag wrong");
  sync_hi_read_a: assert property (
    rd_hi_s |=> reg_rdata == sync_word[15:8]) else $error("sync high readback wrong");
  sync_lo_write_a: assert property (
    wr_lo_s |=> sync_word[7:0] == $past(reg_wdata)) else $error("sync low not written");
  sync_hold_a: assert property (
    !reg_wr |=> $stable(sync_word)) else $error("sync word moved without write");
  idle_ready_a: assert property (
    !synced |-> !rx_byte_ready) else $error("byte taken before sync");
  flush_empty_a: assert property (
    pkt_flushed |-> ##[0:2] rx_fifo_count == 0) else $error("flush left bytes");
  drop_clean_a: assert property (
    pkt_drop |-> $stable(rx_fifo_count)) else $error("dropped packet reached fifo");
endmodule // phc_asserts
bind phc_packet_handler phc_asserts #(.CW(CW)) u_phc_asserts (.clk, .rst_b, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .rx_sync_found, .rx_byte_ready, .sync_word,
  .rx_fifo_count, .rx_thr_hit, .tx_fifo_count, .tx_thr_hit, .pkt_drop, .pkt_flushed);

//--- tb/phc_demod_model.sv
`timescale 1ns/1ps
module phc_demod_model (
  // Clock
  input  wire        clk,
  // Byte stream
  output logic       rx_sync_found,
  output logic       rx_byte_valid,
  input  wire        rx_byte_ready,
  output logic [7:0] rx_byte,
  output logic       rx_pkt_end,
  output logic       rx_crc_ok,
  output logic [7:0] rx_rssi
);
  initial begin
    {rx_sync_found, rx_byte_valid, rx_pkt_end, rx_crc_ok} = 4'h0;
    rx_byte = 8'h00;
    rx_rssi = 8'h00;
  end
  // Ready is sampled mid-cycle; inputs only move at the rising edge
  task automatic frame(input logic [7:0] b[$], input logic crc);
    @(posedge clk);
    rx_sync_found <= 1'b1;
    @(posedge clk);
    rx_sync_found <= 1'b0;
    foreach (b[i]) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= b[i];
      do @(negedge clk); while (rx_byte_ready !== 1'b1);
      @(posedge clk);
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_pkt_end <= 1'b1;
    rx_crc_ok <= crc;
    rx_rssi <= 8'h5a;
    @(posedge clk);
    rx_pkt_end <= 1'b0;
    rx_crc_ok <= ~crc;
    rx_rssi <= 8'ha5;
  endtask
endmodule // phc_demod_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_b, reg_wr, reg_rd, rx_fifo_rd, tx_thr_hit, pkt_drop, pkt_flushed;
  logic        rx_sync_found, rx_byte_valid, rx_byte_ready, rx_pkt_end, rx_crc_ok, rx_thr_hit;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rx_byte, rx_rssi, rx_fifo_data;
  logic [15:0] sync_word;
  logic [6:0]  rx_fifo_count, tx_fifo_count;
  logic [7:0]  pk[$];
  int          fails = 0, samples_checked = 0, ndrop = 0, nflush = 0;
  phc_packet_handler u_phc_packet_handler (.clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .rx_sync_found, .rx_byte_valid, .rx_byte_ready, .rx_byte,
    .rx_pkt_end, .rx_crc_ok, .rx_rssi, .sync_word, .rx_fifo_rd, .rx_fifo_data,
    .rx_fifo_count, .rx_thr_hit, .tx_fifo_count, .tx_thr_hit, .pkt_drop, .pkt_flushed);
  phc_demod_model u_phc_demod_model (.clk, .rx_sync_found, .rx_byte_valid, .rx_byte_ready,
    .rx_byte, .rx_pkt_end, .rx_crc_ok, .rx_rssi);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    ndrop += pkt_drop;
    nflush += pkt_flushed;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("register", e, reg_rdata);
  endtask
  task automatic pc(input logic [7:0] e);
    @(posedge clk);
    rx_fifo_rd <= 1'b1;
    @(posedge clk);
    rx_fifo_rd <= 1'b0;
    @(negedge clk);
    chk("fifo byte", e, rx_fifo_data);
  endtask
  task automatic send(input logic crc, input int n);
    u_phc_demod_model.frame(pk, crc);
    repeat (20) if (8'(rx_fifo_count) !== 8'(n)) @(negedge clk);
    chk("fifo count", 8'(n), 8'(rx_fifo_count));
  endtask
  task automatic drain(input bit tr, input logic [7:0] st);
    foreach (pk[i]) pc(pk[i]);
    if (tr) begin
      pc(8'h5a);
      pc(st);
    end
  endtask
  task automatic t_regs;
    rc(6'h03, 8'h07);
    rc(6'h04, 8'hd3);
    rc(6'h05, 8'h91);
    rc(6'h06, 8'hff);
    rc(6'h07, 8'h04);
    rc(6'h08, 8'h45);
    wr(6'h3f, 8'h5c);
    rc(6'h3f, 8'h00);
    wr(6'h04, 8'ha5);
    wr(6'h05, 8'h3c);
    rc(6'h04, 8'ha5);
    chk("sync high", 8'ha5, sync_word[15:8]);
    chk("sync low", 8'h3c, sync_word[7:0]);
    wr(6'h07, 8'hff);
    rc(6'h07, 8'hef);
    wr(6'h07, 8'h04);
  endtask
  task automatic t_thr;
    for (int n = 0; n < 16; n++) begin
      wr(6'h03, 8'(n));
      tx_fifo_count <= 7'(61 - 4 * n);
      @(negedge clk);
      chk("tx level at", 8'h01, 8'(tx_thr_hit));
      @(posedge clk);
      tx_fifo_count <= 7'(60 - 4 * n);
      @(negedge clk);
      chk("tx level below", 8'h00, 8'(tx_thr_hit));
    end
  endtask
  // Level 64 with the buffer full: the source must stall, not lose bytes
  task automatic t_full;
    wr(6'h07, 8'h00);
    wr(6'h08, 8'h44);
    wr(6'h06, 8'h42);
    pk = {};
    for (int i = 0; i < 66; i++) pk.push_back(8'(i));
    fork
      u_phc_demod_model.frame(pk, 1'b1);
      begin
        repeat (300) if (8'(rx_fifo_count) !== 8'h40) @(negedge clk);
        repeat (4) @(negedge clk);
        chk("full level", 8'h01, 8'(rx_thr_hit));
        chk("refused", 8'h00, 8'(rx_byte_ready));
        drain(1'b0, 8'h00);
      end
    join
    wr(6'h08, 8'h45);
    wr(6'h06, 8'hff);
    wr(6'h07, 8'h04);
  endtask
  task automatic t_var;
    pk = {8'h03, 8'h11, 8'h22, 8'h33};
    send(1'b0, 6);
    wr(6'h03, 8'h00);
    @(negedge clk);
    chk("rx level at", 8'h01, 8'(rx_thr_hit));
    wr(6'h03, 8'h01);
    @(negedge clk);
    chk("rx level below", 8'h00, 8'(rx_thr_hit));
    wr(6'h03, 8'h07);
    drain(1'b1, 8'h00);
  endtask
  task automatic t_addr;
    logic [7:0] a[4];
    bit         ok;
    int         d0;
    a = '{8'h2c, 8'h00, 8'hff, 8'h47};
    wr(6'h09, 8'h2c);
    for (int m = 0; m < 4; m++) begin
      wr(6'h07, 8'(m));
      for (int k = 0; k < 4; k++) begin
        ok = m == 0 || k == 0 || (m >= 2 && k == 1) || (m == 3 && k == 2);
        d0 = ndrop;
        pk = {8'h02, a[k], 8'h77};
        send(1'b1, ok ? 3 : 0);
        chk("drop pulse", 8'(!ok), 8'(ndrop - d0));
        if (ok) drain(1'b0, 8'h00);
      end
    end
    // Fixed length with the filter on: address byte is the first payload byte
    wr(6'h08, 8'h44);
    wr(6'h06, 8'h02);
    wr(6'h07, 8'h01);
    for (int k = 0; k < 4; k += 3) begin
      d0 = ndrop;
      pk = {a[k], 8'h66};
      send(1'b1, k == 0 ? 2 : 0);
      chk("fixed drop", 8'(k != 0), 8'(ndrop - d0));
      if (k == 0) drain(1'b0, 8'h00);
    end
    wr(6'h08, 8'h45);
    wr(6'h06, 8'hff);
    wr(6'h07, 8'h04);
  endtask
  task automatic t_len;
    int d0;
    wr(6'h07, 8'h00);
    wr(6'h06, 8'h02);
    d0 = ndrop;
    pk = {8'h03, 8'h01, 8'h02, 8'h03};
    send(1'b1, 0);
    chk("long drop", 8'h01, 8'(ndrop - d0));
    pk = {8'h02, 8'h0a, 8'h0b};
    send(1'b1, 3);
    drain(1'b0, 8'h00);
    wr(6'h08, 8'h44);
    pk = {8'h0c, 8'h0d};
    send(1'b1, 2);
    drain(1'b0, 8'h00);
    wr(6'h08, 8'h45);
    wr(6'h06, 8'hff);
  endtask
  task automatic t_flush;
    int f0;
    wr(6'h07, 8'h0c);
    f0 = nflush;
    pk = {8'h02, 8'h44, 8'h55};
    send(1'b0, 0);
    chk("flush pulse", 8'h01, 8'(nflush - f0));
    send(1'b1, 5);
    drain(1'b1, 8'h80);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fails++;
    close_out;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, rx_fifo_rd} = 4'h0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    tx_fifo_count = 7'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_thr;
    t_full;
    t_var;
    t_addr;
    t_len;
    t_flush;
    close_out;
  end
endmodule // tb_top
